// ===== hw/fpl_host.sv
// Host controller driving a parallel flash's password and lock features.
`timescale 1ns/1ns
module fpl_host #(
  parameter int AW = 23,
  parameter int DW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [DW-1:0] flash_dq_i,
  output logic [DW-1:0] flash_dq_o,
  output logic flash_dq_oe_n,
  output logic [AW-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_rst_n,
  output logic flash_wp_n
);
  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  function automatic logic mapped(input logic [31:0] a);
    mapped = a[31:8] == 24'h000000 && (a[7:0] == fpl_pkg::CTRL_OFS
             || a[7:0] == fpl_pkg::ADDR_OFS || a[7:0] == fpl_pkg::WDATA_OFS
             || a[7:0] == fpl_pkg::STATUS_OFS);
  endfunction

  logic acc_done;
  logic wr_ctrl;
  assign acc_done = psel && penable && pready;
  assign wr_ctrl = acc_done && pwrite && paddr == 32'(fpl_pkg::CTRL_OFS);

  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic busy_r;
  logic rd_r;
  logic [1:0] tag_r;
  logic pw_mode_r;
  logic err_r;
  logic locked_r;
  logic [DW-1:0] last_rd_r;
  logic [7:0] verify_cnt_r;
  logic [1:0] words_r;
  logic [7:0] rst_cnt_r;
  logic cyc_start_r;
  logic cyc_done;
  logic [DW-1:0] cyc_rdata;

  // Request checks made when software launches a cycle.
  logic start_req;
  logic [1:0] req_tag;
  logic refuse;
  assign start_req = wr_ctrl && pwdata[fpl_pkg::CTRL_START_BIT];
  assign req_tag = pwdata[fpl_pkg::CTRL_TAG_LSB +: 2];
  always_comb begin
    // Cycles never overlap, so a lock command cannot overtake the guard-bit
    // programs that software issued before it.
    refuse = busy_r || rst_cnt_r != 8'h00;
    // A cycle started together with a reset pulse would run into the reset.
    if (pwdata[fpl_pkg::CTRL_RST_BIT]) begin
      refuse = 1'b1;
    end
    // A password submit outside the entry/exit bracket is never sent.
    if (req_tag == fpl_pkg::FPL_TAG_PW_SUBMIT && !pw_mode_r) begin
      refuse = 1'b1;
    end
    // The device needs time to verify; a new submit would be lost.
    if (req_tag == fpl_pkg::FPL_TAG_PW_SUBMIT && verify_cnt_r != 8'h00) begin
      refuse = 1'b1;
    end
    // Once locked for good the password feature is dead; save the traffic.
    if (req_tag != fpl_pkg::FPL_TAG_PLAIN && locked_r) begin
      refuse = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave, one wait state on every access
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped(paddr);
      prdata <= 32'h00000000;
      if (!pwrite && paddr == 32'(fpl_pkg::STATUS_OFS)) begin
        prdata[fpl_pkg::ST_BUSY_BIT] <= busy_r || rst_cnt_r != 8'h00;
        prdata[fpl_pkg::ST_PWMODE_BIT] <= pw_mode_r;
        prdata[fpl_pkg::ST_VERIFY_BIT] <= verify_cnt_r != 8'h00;
        prdata[fpl_pkg::ST_ERR_BIT] <= err_r;
        prdata[fpl_pkg::ST_LOCKED_BIT] <= locked_r;
        prdata[fpl_pkg::ST_WP_BIT] <= flash_wp_n;
        // Software confirms the lock bit here after a trial submit.
        prdata[fpl_pkg::ST_RDATA_LSB +: DW] <= last_rd_r;
      end else if (!pwrite && paddr == 32'(fpl_pkg::ADDR_OFS)) begin
        prdata[AW-1:0] <= addr_r;
      end else if (!pwrite && paddr == 32'(fpl_pkg::WDATA_OFS)) begin
        prdata[DW-1:0] <= wdata_r;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Address, data and pin control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= '0;
      wdata_r <= '0;
    end else if (acc_done && pwrite && !busy_r) begin
      if (paddr == 32'(fpl_pkg::ADDR_OFS)) begin
        addr_r <= pwdata[AW-1:0];
      end
      if (paddr == 32'(fpl_pkg::WDATA_OFS)) begin
        wdata_r <= pwdata[DW-1:0];
      end
    end
  end

  // Boot-area changes need the pin high; software raises it beforehand.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_wp_n <= fpl_pkg::WP_RESET;
    end else if (wr_ctrl) begin
      flash_wp_n <= pwdata[fpl_pkg::CTRL_WP_BIT];
    end
  end

  // A reset pulse drops the device's global lock only in pwm mode and not once locked for good; the host leaves password mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_r <= 8'h00;
      flash_rst_n <= 1'b1;
    end else if (wr_ctrl && pwdata[fpl_pkg::CTRL_RST_BIT] && !busy_r) begin
      rst_cnt_r <= 8'(fpl_pkg::RST_PULSE_CYC);
      flash_rst_n <= 1'b0;
    end else if (rst_cnt_r != 8'h00) begin
      rst_cnt_r <= rst_cnt_r - 8'h01;
      flash_rst_n <= rst_cnt_r == 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Cycle launch and sequence tracking
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      cyc_start_r <= 1'b0;
      rd_r <= 1'b0;
      tag_r <= 2'b00;
    end else begin
      cyc_start_r <= 1'b0;
      if (start_req && !refuse) begin
        busy_r <= 1'b1;
        cyc_start_r <= 1'b1;
        rd_r <= pwdata[fpl_pkg::CTRL_READ_BIT];
        tag_r <= req_tag;
      end else if (cyc_done) begin
        busy_r <= 1'b0;
      end
    end
  end

  // A refused launch is flagged; a new error wins over a clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 1'b0;
    end else if (start_req && refuse) begin
      err_r <= 1'b1;
    end else if (wr_ctrl && pwdata[fpl_pkg::CTRL_ERRCLR_BIT]) begin
      err_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw_mode_r <= 1'b0;
    end else if (rst_cnt_r != 8'h00) begin
      pw_mode_r <= 1'b0;
    end else if (cyc_done && tag_r == fpl_pkg::FPL_TAG_PW_ENTRY) begin
      pw_mode_r <= 1'b1;
    end else if (cyc_done && tag_r == fpl_pkg::FPL_TAG_PW_EXIT) begin
      pw_mode_r <= 1'b0;
    end
  end

  // Words are counted, not matched: the device compares each by address.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      words_r <= 2'b00;
      verify_cnt_r <= 8'h00;
    end else if (cyc_done && !rd_r
                 && tag_r == fpl_pkg::FPL_TAG_PW_SUBMIT) begin
      words_r <= words_r + 2'b01;
      if (words_r == 2'(fpl_pkg::PW_WORDS - 1)) begin
        verify_cnt_r <= 8'(fpl_pkg::VERIFY_CYC);
      end
    end else if (verify_cnt_r != 8'h00) begin
      verify_cnt_r <= verify_cnt_r - 8'h01;
    end
  end

  // Read data; an identification read of the lock word updates the flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_rd_r <= '0;
      locked_r <= 1'b0;
    end else if (cyc_done && rd_r) begin
      last_rd_r <= cyc_rdata;
      if (addr_r == fpl_pkg::ID_LOCK_ADDR) begin
        locked_r <= !cyc_rdata[fpl_pkg::ID_LOCK_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin cycle engine
  // ----------------------------------------------------------------------
  fpl_cyc #(
    .AW(AW),
    .DW(DW)
  ) u_cyc (
    .pclk(pclk),
    .presetn(presetn),
    .start(cyc_start_r),
    .rd(rd_r),
    .addr(addr_r),
    .wdata(wdata_r),
    .flash_dq_i(flash_dq_i),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe_n(flash_dq_oe_n),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n)
  );
endmodule // fpl_host

// ===== hw/fpl_pkg.sv
// Shared constants for the flash password and block-lock host controller.
package fpl_pkg;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int VERIFY_TIME_NS = 2000;
  localparam int VERIFY_CYC = (VERIFY_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int READ_ACCESS_NS = 90;
  localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1)
                            / CLK_PERIOD_NS;
  localparam int WE_PULSE_CYC = 4;
  localparam int HOLD_CYC = 2;
  localparam int RST_PULSE_CYC = 50;
  localparam int PW_WORDS = 4;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] WDATA_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_READ_BIT = 1;
  localparam int CTRL_TAG_LSB = 2;
  localparam int CTRL_WP_BIT = 4;
  localparam int CTRL_RST_BIT = 5;
  localparam int CTRL_ERRCLR_BIT = 6;

  localparam int ST_BUSY_BIT = 0;
  localparam int ST_PWMODE_BIT = 1;
  localparam int ST_VERIFY_BIT = 2;
  localparam int ST_ERR_BIT = 3;
  localparam int ST_LOCKED_BIT = 4;
  localparam int ST_WP_BIT = 5;
  localparam int ST_RDATA_LSB = 16;

  localparam logic WP_RESET = 1'b0;

  // Tag carried by a cycle so the controller can track the sequence.
  typedef enum logic [1:0] {
    FPL_TAG_PLAIN,
    FPL_TAG_PW_ENTRY,
    FPL_TAG_PW_EXIT,
    FPL_TAG_PW_SUBMIT
  } fpl_tag_e;

  // Identification-mode address whose bit 0 reads low once locked for good.
  localparam logic [22:0] ID_LOCK_ADDR = 23'h0005FE;
  localparam int ID_LOCK_BIT = 0;
endpackage

// ===== hw/fpl_cyc.sv
// One asynchronous read or write cycle on the flash pins.
`timescale 1ns/1ns
module fpl_cyc #(
  parameter int AW = 23,
  parameter int DW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic rd,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic [DW-1:0] flash_dq_i,
  output logic done,
  output logic [DW-1:0] rdata,
  output logic [AW-1:0] flash_addr,
  output logic [DW-1:0] flash_dq_o,
  output logic flash_dq_oe_n,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  // ----------------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------------
  logic [DW-1:0] s1_r, s2_r, s3_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= flash_dq_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ----------------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD} fpl_cy_e;
  fpl_cy_e st_r;
  logic rd_r;
  logic [7:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= CY_IDLE;
      rd_r <= 1'b0;
      cnt_r <= 8'h00;
      done <= 1'b0;
      rdata <= '0;
      flash_addr <= '0;
      flash_dq_o <= '0;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (st_r)
        CY_IDLE: begin
          if (start) begin
            rd_r <= rd;
            flash_addr <= addr;
            flash_dq_o <= wdata;
            flash_dq_oe_n <= rd;
            flash_ce_n <= 1'b0;
            flash_oe_n <= !rd;
            st_r <= CY_SETUP;
          end
        end
        CY_SETUP: begin
          flash_we_n <= rd_r;
          cnt_r <= rd_r ? 8'(fpl_pkg::READ_CYC + 3)
                        : 8'(fpl_pkg::WE_PULSE_CYC);
          st_r <= CY_PULSE;
        end
        CY_PULSE: begin
          if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            flash_we_n <= 1'b1;
            cnt_r <= 8'(fpl_pkg::HOLD_CYC);
            st_r <= CY_HOLD;
          end
        end
        CY_HOLD: begin
          // A read only ends once the synchronised data has settled.
          if (rd_r && s2_r != s3_r) begin
            cnt_r <= cnt_r;
          end else if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            if (rd_r) begin
              rdata <= s3_r;
            end
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_dq_oe_n <= 1'b1;
            done <= 1'b1;
            st_r <= CY_IDLE;
          end
        end
        default: st_r <= CY_IDLE;
      endcase
    end
  end
endmodule // fpl_cyc

// ===== verification/fpl_host_chk.sv
// Port-level checker for the flash password host controller.
`timescale 1ns/1ns
module fpl_host_chk #(
  parameter int AW = 23,
  parameter int DW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic flash_dq_oe_n,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_rst_n
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  logic [7:0] rst_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rst_cnt_r <= 8'h00;
    else if (!flash_rst_n) rst_cnt_r <= rst_cnt_r + 8'h01;
    else rst_cnt_r <= 8'h00;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_wait_a: assert property (psel && penable && !$past(penable)
    |-> !pready ##1 pready) else $error("pready not after one wait");
  pready_once_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_reply_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error reply malformed");
  write_strobe_a: assert property (
    !flash_we_n |-> flash_oe_n && !flash_ce_n && !flash_dq_oe_n)
    else $error("write strobe without select or data");
  read_drive_a: assert property (
    !flash_oe_n |-> flash_dq_oe_n && !flash_ce_n)
    else $error("host drives data during read");
  write_width_a: assert property ($fell(flash_we_n)
    |-> (!flash_we_n)[*4] ##1 (flash_we_n && !flash_ce_n)[*2])
    else $error("write pulse or hold wrong");
  read_hold_a: assert property ($fell(flash_oe_n)
    |-> (!flash_oe_n)[*8] ##1 (!flash_oe_n)[*5])
    else $error("read strobe too short");
  rst_width_a: assert property ($rose(flash_rst_n)
    |-> rst_cnt_r == 8'(fpl_pkg::RST_PULSE_CYC))
    else $error("reset pulse width wrong");
  rst_quiet_a: assert property (!flash_rst_n |-> flash_ce_n)
    else $error("flash selected during reset pulse");
  cover property ($fell(flash_we_n));
  cover property ($fell(flash_oe_n));
  cover property (pslverr);
  cover property ($rose(flash_rst_n));
endmodule // fpl_host_chk

bind fpl_host fpl_host_chk #(.AW(AW), .DW(DW)) i_fpl_host_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_rst_n(flash_rst_n));

// ===== verification/fpl_flash_model.sv
// Behavioural model of the flash password and lock logic.
`timescale 1ns/1ns
module fpl_flash_model (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rst_n,
  input wire logic wp_n,
  input wire logic [22:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out
);
  // ----------------------------------------------------------------------
  // Command decode by address; the map is arbitrary for this model.
  // ----------------------------------------------------------------------
  logic [15:0] pw [4] = '{default: 16'hFFFF};
  logic [1:0] mode = 2'b11;
  logic glock = 1'b1;
  logic irr = 1'b0;
  logic vbusy = 1'b0;
  logic [3:0] hit = 4'h0;
  logic [1:0] nsub = 2'd0;
  logic [15:0] rv;
  logic [15:0] last = 16'h0;
  // One guard bit and one data word per block; block 0 is the boot area.
  logic [7:0] guard = 8'hFF;
  logic [15:0] mem [8] = '{default: 16'hFFFF};
  wire [2:0] blk = addr[21:19];
  wire pwm = (mode == 2'b01);
  always @(negedge rst_n) if (pwm && !irr) glock = 1'b0;
  always @(posedge we_n) if (!ce_n && rst_n) begin
    if (addr[22:2] == 21'd0 && !pwm && !irr)
      pw[addr[1:0]] = pw[addr[1:0]] & dq_in;
    if (addr[22:2] == 21'd2 && !vbusy && !irr) begin
      hit[addr[1:0]] = (dq_in == pw[addr[1:0]]);
      nsub = nsub + 2'd1;
      if (nsub == 2'd0) fork
        begin
          vbusy = 1'b1;
          #2000;
          if (&hit) glock = 1'b1;
          vbusy = 1'b0;
        end
      join_none
    end
    if (addr == 23'h10 && !irr) glock = 1'b0;
    if (addr == 23'h11 && !irr) begin
      if ((mode & dq_in[2:1]) != 2'b00) mode = mode & dq_in[2:1];
      // The new mode counts at once; the pwm net still shows the old one.
      if (mode == 2'b01) glock = 1'b0;
    end
    if (addr == 23'h12 && glock) irr = 1'b1;
    // A guarded block never changes; the pin only matters for open boot.
    if (addr[22] && guard[blk] && (blk != 3'h0 || wp_n))
      mem[blk] = mem[blk] & dq_in;
    if (addr == 23'h13 && glock && !irr) guard[dq_in[2:0]] = 1'b0;
    if (addr == 23'h14 && glock && !irr) guard = 8'hFF;
  end
  always_comb begin
    if (addr[22:2] == 21'd0) rv = pwm ? 16'hFFFF : pw[addr[1:0]];
    else if (addr == 23'h10) rv = {15'h0, glock};
    else if (addr == 23'h5FE) rv = {15'h7FFF, ~irr};
    else if (addr == 23'h13) rv = {8'h00, guard};
    else if (addr[22]) rv = mem[blk];
    else rv = 16'h0;
  end
  // A released bus shows the inverse of its last value, never a stale copy.
  always @(ce_n or oe_n or rv) begin
    if (!ce_n && !oe_n) begin
      dq_out = rv;
      last = rv;
    end else dq_out = ~last;
  end
endmodule // fpl_flash_model

// ===== verification/fpl_host_tb.sv
// Self-checking testbench of the flash password host controller.
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module fpl_host_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [15:0] dq_o, dq_m;
  logic [22:0] fa;
  logic dq_oe_n, ce_n, oe_n, we_n, rst_n, wp_n;
  int n_fail = 0;
  int tests_run = 0;
  logic wp_lvl = 1'b1;
  logic [15:0] pw [4] = '{16'h1234, 16'hA5C3, 16'h0F0F, 16'h7E81};
  wire [15:0] dq_bus = dq_oe_n ? dq_m : dq_o;
  fpl_host i_fpl_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_dq_i(dq_bus), .flash_dq_o(dq_o), .flash_dq_oe_n(dq_oe_n),
    .flash_addr(fa), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_rst_n(rst_n), .flash_wp_n(wp_n));
  fpl_flash_model i_fpl_flash_model (.ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .rst_n(rst_n), .wp_n(wp_n), .addr(fa), .dq_in(dq_bus),
    .dq_out(dq_m));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle(input int bit_no);
    int k;
    k = 0;
    do begin
      apb(1'b0, 8'h0C, 32'h0);
      k++;
    end while (rd[bit_no] !== 1'b0 && k < 300);
    if (k >= 300) n_fail++;
  endtask
  task automatic fop(input logic r, input logic [1:0] tag,
                     input logic [22:0] a, input logic [15:0] d);
    apb(1'b1, 8'h04, {9'h0, a});
    apb(1'b1, 8'h08, {16'h0, d});
    apb(1'b1, 8'h00, {26'h0, 1'b0, wp_lvl, tag, r, 1'b1});
    idle(0);
  endtask
  task automatic submit(input logic [15:0] w0);
    fop(1'b0, 2'd1, 23'h20, 16'h0);
    for (int i = 3; i >= 0; i--) fop(1'b0, 2'd3, 23'h8 + 23'(i),
                                     i == 0 ? w0 : pw[i]);
    idle(2);
    fop(1'b1, 2'd0, 23'h10, 16'h0);
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    `CHK({ce_n, oe_n, we_n, dq_oe_n, rst_n, wp_n}, 6'b111110)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b0, 8'h00, 32'h0);
    `CHK({er, rd}, {1'b0, 32'h0})
    fop(1'b0, 2'h3, 23'h8, 16'h0);
    `CHK(rd[3:1], 3'b100)
    apb(1'b1, 8'h00, 32'h50);
  endtask
  task automatic t_program;
    fop(1'b0, 2'd1, 23'h20, 16'h0);
    fop(1'b1, 2'd0, 23'h0, 16'h0);
    `CHK(rd[31:16], 16'hFFFF)
    `CHK(wp_n, 1'b1)
    for (int i = 0; i < 4; i++) begin
      fop(1'b0, 2'd0, 23'(i), pw[i]);
      fop(1'b1, 2'd0, 23'(i), 16'h0);
      `CHK(rd[31:16], pw[i])
    end
    fop(1'b0, 2'd0, 23'h0, 16'hFFFF);
    fop(1'b1, 2'd0, 23'h0, 16'h0);
    `CHK(rd[31:16], pw[0])
  endtask
  task automatic t_submit;
    fop(1'b0, 2'd0, 23'h10, 16'h0);
    fop(1'b1, 2'd0, 23'h10, 16'h0);
    `CHK(rd[16], 1'b0)
    fop(1'b0, 2'd1, 23'h20, 16'h0);
    for (int i = 3; i >= 0; i--) fop(1'b0, 2'd3, 23'h8 + 23'(i), pw[i]);
    fop(1'b0, 2'd3, 23'h8, pw[0]);
    `CHK(rd[3], 1'b1)
    idle(2);
    fop(1'b1, 2'd0, 23'h10, 16'h0);
    `CHK(rd[16], 1'b1)
    fop(1'b0, 2'h2, 23'h24, 16'h0);
    `CHK(rd[1], 1'b0)
    apb(1'b1, 8'h00, 32'h50);
  endtask
  task automatic t_mode;
    fop(1'b0, 2'd0, 23'h11, 16'hFFF9);
    fop(1'b1, 2'd0, 23'h1, 16'h0);
    `CHK(rd[31:16], pw[1])
    fop(1'b0, 2'd0, 23'h11, 16'hFFFB);
    fop(1'b1, 2'd0, 23'h10, 16'h0);
    `CHK(rd[16], 1'b0)
    fop(1'b0, 2'd0, 23'h1, 16'h0000);
    fop(1'b1, 2'd0, 23'h1, 16'h0);
    `CHK(rd[31:16], 16'hFFFF)
    submit(pw[0]);
    `CHK(rd[16], 1'b1)
    apb(1'b1, 8'h00, 32'h30);
    idle(0);
    fop(1'b1, 2'd0, 23'h10, 16'h0);
    `CHK(rd[16], 1'b0)
    submit(16'h0000);
    `CHK(rd[16], 1'b0)
  endtask
  task automatic t_irr;
    fop(1'b0, 2'd0, 23'h12, 16'h0);
    fop(1'b1, 2'd0, 23'h5FE, 16'h0);
    `CHK(rd[16], 1'b1)
    fop(1'b0, 2'h0, 23'h13, 16'h0001);
    fop(1'b1, 2'h0, 23'h13, 16'h0);
    `CHK(rd[31:16], 16'h00FF)
    submit(pw[0]);
    wp_lvl = 1'b0;
    fop(1'b0, 2'h0, 23'h500000, 16'h1234);
    fop(1'b0, 2'h0, 23'h400000, 16'h0000);
    `CHK({wp_n, rd[5]}, 2'b00)
    fop(1'b1, 2'h0, 23'h500000, 16'h0);
    `CHK(rd[31:16], 16'h1234)
    fop(1'b1, 2'h0, 23'h400000, 16'h0);
    `CHK(rd[31:16], 16'hFFFF)
    wp_lvl = 1'b1;
    fop(1'b0, 2'h0, 23'h13, 16'h0001);
    fop(1'b0, 2'h0, 23'h13, 16'h0000);
    fop(1'b0, 2'h0, 23'h480000, 16'h0000);
    fop(1'b1, 2'h0, 23'h480000, 16'h0);
    `CHK(rd[31:16], 16'hFFFF)
    fop(1'b1, 2'h0, 23'h13, 16'h0);
    `CHK(rd[31:16], 16'h00FC)
    fop(1'b0, 2'd0, 23'h12, 16'h0);
    fop(1'b1, 2'd0, 23'h5FE, 16'h0);
    `CHK({rd[16], rd[4]}, 2'b01)
    fop(1'b0, 2'h0, 23'h14, 16'h0);
    fop(1'b0, 2'h0, 23'h400000, 16'h0000);
    fop(1'b1, 2'h0, 23'h400000, 16'h0);
    `CHK(rd[31:16], 16'hFFFF)
    fop(1'b1, 2'h0, 23'h13, 16'h0);
    `CHK(rd[31:16], 16'h00FC)
    fop(1'b0, 2'd0, 23'h10, 16'h0);
    fop(1'b1, 2'd0, 23'h10, 16'h0);
    `CHK(rd[16], 1'b1)
  endtask
  task automatic complete_run;
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #500000;
    n_fail++;
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'b0000;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_program();
    t_submit();
    t_mode();
    t_irr();
    complete_run();
  end
endmodule // fpl_host_tb
